// ==== logic/ssl_defines.svh ====
// Offsets, field positions, reset values and strap decoding for the supply register slice
// Contract
// R1 - Health bit 24 reads one while the on-chip oscillator is stable.
// R2 - Health bit 19 shows PLL rail good, bit 16 core rail good.
// R3 - Bit 9 flags analog converter current limit, bit 8 core converter limit.
// R4 - Bit 1 flags analog converter soft-start, bit 0 core converter soft-start.
// R5 - Core level is writable 7 bits at 6:0, 0.60V plus 10 mV per code.
// R6 - Software moves core level at most 10 mV per microsecond.
// R7 - Both level fields load strap-derived defaults at reset.
// R8 - PLL regulator level is writable 3 bits at 2:0, 100 mV per code.
// R9 - Software raises PLL regulator level one code at a time.
// R10 - Reserved bits read zero, writes ignored; health register ignores writes.
`ifndef SSL_DEFINES_SVH
`define SSL_DEFINES_SVH

`define SSL_ADDR_W 8
`define SSL_OFF_HEALTH 8'h30
`define SSL_OFF_CORE 8'h34
`define SSL_OFF_PLL 8'h40
`define SSL_OFF_IRQ_STAT 8'h50
`define SSL_OFF_IRQ_MASK 8'h54

`define SSL_BIT_OSC 24
`define SSL_BIT_PLL_PG 19
`define SSL_BIT_CORE_PG 16
`define SSL_BIT_ANA_ILIM 9
`define SSL_BIT_CORE_ILIM 8
`define SSL_BIT_ANA_SS 1
`define SSL_BIT_CORE_SS 0

`define SSL_CORE_W 7
`define SSL_PLL_W 3
`define SSL_EVT_W 7

`define SSL_CORE_DEF_0 7'h28
`define SSL_CORE_DEF_1 7'h2D
`define SSL_CORE_DEF_2 7'h32
`define SSL_CORE_DEF_3 7'h46
`define SSL_PLL_DEF_0 3'h4
`define SSL_PLL_DEF_1 3'h4
`define SSL_PLL_DEF_2 3'h5
`define SSL_PLL_DEF_3 3'h6

`endif

// ==== logic/ssl_pkg.sv ====
// Types shared by the supply register slice
package ssl_pkg;
	typedef enum logic [1:0] {
		SSL_ST_LOAD = 2'b01,
		SSL_ST_RUN = 2'b10
	} ssl_state_t;
endpackage : ssl_pkg

// ==== logic/ssl_regs.sv ====
// Supply health and rail level register slice with event interrupt
`include "ssl_defines.svh"

module ssl_regs
	import ssl_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic osc_stable,
	input wire logic pll_supply_rail_good,
	input wire logic core_supply_rail_good,
	input wire logic analog_switching_converter_ilim,
	input wire logic core_switching_converter_ilim,
	input wire logic analog_switching_converter_softstart,
	input wire logic core_switching_converter_softstart,
	input wire logic [1:0] strap_mode,
	output logic [6:0] core_level,
	output logic [2:0] pll_linear_regulator_level,
	output logic irq
);
	// Two-stage synchronisers for status pins and straps
	logic [8:0] sync1_q;
	logic [8:0] sync2_q;
	wire [8:0] raw_in = {strap_mode, osc_stable, pll_supply_rail_good, core_supply_rail_good,
		analog_switching_converter_ilim, core_switching_converter_ilim,
		analog_switching_converter_softstart, core_switching_converter_softstart};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= 9'h000;
			sync2_q <= 9'h000;
		end else begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
		end
	end

	wire [6:0] stat = sync2_q[6:0];
	wire [1:0] strap = sync2_q[8:7];

	// Health word assembly
	wire [31:0] health_word;
	assign health_word[31:25] = 7'h00; // R10
	assign health_word[`SSL_BIT_OSC] = stat[6]; // R1
	assign health_word[23:20] = 4'h0;
	assign health_word[`SSL_BIT_PLL_PG] = stat[5]; // R2
	assign health_word[18:17] = 2'h0;
	assign health_word[`SSL_BIT_CORE_PG] = stat[4]; // R2
	assign health_word[15:10] = 6'h00;
	assign health_word[`SSL_BIT_ANA_ILIM] = stat[3]; // R3
	assign health_word[`SSL_BIT_CORE_ILIM] = stat[2]; // R3
	assign health_word[7:2] = 6'h00;
	assign health_word[`SSL_BIT_ANA_SS] = stat[1]; // R4
	assign health_word[`SSL_BIT_CORE_SS] = stat[0]; // R4

	// Strap decode for defaults
	wire [6:0] core_def = (strap == 2'h0) ? `SSL_CORE_DEF_0 :
		(strap == 2'h1) ? `SSL_CORE_DEF_1 :
		(strap == 2'h2) ? `SSL_CORE_DEF_2 : `SSL_CORE_DEF_3; // R7
	wire [2:0] pll_def = (strap == 2'h0) ? `SSL_PLL_DEF_0 :
		(strap == 2'h1) ? `SSL_PLL_DEF_1 :
		(strap == 2'h2) ? `SSL_PLL_DEF_2 : `SSL_PLL_DEF_3; // R7

	// Address decode
	wire sel_health = (addr == `SSL_OFF_HEALTH);
	wire sel_core = (addr == `SSL_OFF_CORE);
	wire sel_pll = (addr == `SSL_OFF_PLL);
	wire sel_stat = (addr == `SSL_OFF_IRQ_STAT);
	wire sel_mask = (addr == `SSL_OFF_IRQ_MASK);

	// Strap load: straps settle through the synchroniser first
	ssl_state_t state_q;
	logic [1:0] settle_q;
	wire loading = (state_q == SSL_ST_LOAD);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= SSL_ST_LOAD;
			settle_q <= 2'h0;
		end else begin
			unique case (state_q)
				SSL_ST_LOAD: begin
					settle_q <= settle_q + 2'h1;
					if (settle_q == 2'h2) begin
						state_q <= SSL_ST_RUN;
					end
				end
				SSL_ST_RUN: begin
					settle_q <= settle_q;
				end
			endcase
		end
	end

	// Level registers
	logic [6:0] core_q;
	logic [2:0] pll_q;
	wire [6:0] core_d = loading ? core_def : (wr && sel_core) ? wdata[6:0] : core_q; // R5 R7
	wire [2:0] pll_d = loading ? pll_def : (wr && sel_pll) ? wdata[2:0] : pll_q; // R8 R7

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			core_q <= 7'h00;
			pll_q <= 3'h0;
		end else begin
			core_q <= core_d;
			pll_q <= pll_d;
		end
	end

	// Event capture: rising edges of health bits set sticky status
	logic [6:0] stat_prev_q;
	logic [6:0] ev_q;
	logic [6:0] mask_q;
	wire [6:0] ev_rise = stat & ~stat_prev_q;
	wire [6:0] ev_clr = (wr && sel_stat) ? wdata[6:0] : 7'h00;
	wire [6:0] ev_d = (ev_q & ~ev_clr) | (loading ? 7'h00 : ev_rise);
	wire [6:0] mask_d = (wr && sel_mask) ? wdata[6:0] : mask_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stat_prev_q <= 7'h00;
			ev_q <= 7'h00;
			mask_q <= 7'h00;
			irq <= 1'b0;
		end else begin
			stat_prev_q <= stat;
			ev_q <= ev_d;
			mask_q <= mask_d;
			irq <= |(ev_d & mask_d);
		end
	end

	// Read mux, reserved bits zero, unmapped reads zero
	wire [31:0] rd_mux = sel_health ? health_word :
		sel_core ? {25'h0000000, core_q} :
		sel_pll ? {29'h00000000, pll_q} :
		sel_stat ? {25'h0000000, ev_q} :
		sel_mask ? {25'h0000000, mask_q} : 32'h00000000; // R10

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 32'h00000000;
			core_level <= 7'h00;
			pll_linear_regulator_level <= 3'h0;
		end else begin
			rdata <= rd ? rd_mux : 32'h00000000;
			core_level <= core_d;
			pll_linear_regulator_level <= pll_d;
		end
	end

	AST_HEALTH_RO: assert property (@(posedge clk) disable iff (!resetn) // R10
		(wr && sel_health && !loading) |=> (core_q == $past(core_q) && pll_q == $past(pll_q)))
		else $error("health write disturbed a level");

	AST_OSC_BIT: assert property (@(posedge clk) disable iff (!resetn) // R1
		rd && sel_health |=> rdata[24] == $past(stat[6]))
		else $error("oscillator bit wrong");

	AST_PG_BITS: assert property (@(posedge clk) disable iff (!resetn) // R2
		rd && sel_health |=> rdata[19] == $past(stat[5]) && rdata[16] == $past(stat[4]))
		else $error("power good bits wrong");

	AST_ILIM_BITS: assert property (@(posedge clk) disable iff (!resetn) // R3
		rd && sel_health |=> rdata[9:8] == $past(stat[3:2]))
		else $error("current limit bits wrong");

	AST_SS_BITS: assert property (@(posedge clk) disable iff (!resetn) // R4
		rd && sel_health |=> rdata[1:0] == $past(stat[1:0]) && rdata[7:2] == 6'h00)
		else $error("soft-start bits wrong");

	// Assertion steps: bus accesses and flag rises; the write-read ones are a level write, a cycle with no write to that register, then a read of the same register
	sequence s_core_wr;
		wr && sel_core && !loading;
	endsequence

	sequence s_core_wr_rd;
		(wr && sel_core && !loading) ##1 !(wr && sel_core) ##1 (rd && sel_core);
	endsequence

	sequence s_pll_wr;
		wr && sel_pll && !loading;
	endsequence

	sequence s_pll_wr_rd;
		(wr && sel_pll && !loading) ##1 !(wr && sel_pll) ##1 (rd && sel_pll);
	endsequence

	sequence s_flag_rise;
		!loading && ev_rise != 7'h00;
	endsequence

	sequence s_stat_clr;
		wr && sel_stat && !loading;
	endsequence

	sequence s_mask_wr;
		wr && sel_mask;
	endsequence

	sequence s_health_rd;
		rd && sel_health;
	endsequence

	sequence s_unmapped_rd;
		rd && !(sel_health || sel_core || sel_pll || sel_stat || sel_mask);
	endsequence

	AST_CORE_WR: assert property (@(posedge clk) disable iff (!resetn) // R5
		s_core_wr
		|=> core_level == $past(wdata[6:0]) && core_q == $past(wdata[6:0]))
		else $error("core level write lost");

	AST_CORE_WR_RD: assert property (@(posedge clk) disable iff (!resetn) // R5 R10
		s_core_wr_rd
		|=> rdata == {25'h0000000, $past(wdata[6:0], 3)})
		else $error("core level read back wrong");

	AST_CORE_RD: assert property (@(posedge clk) disable iff (!resetn) // R10
		rd && sel_core && !loading |=> rdata[31:7] == 25'h0000000 && rdata[6:0] == core_level)
		else $error("core level read wrong");

	AST_CORE_HOLD: assert property (@(posedge clk) disable iff (!resetn) // R5
		!loading && !(wr && sel_core)
		|=> $stable(core_level))
		else $error("core level moved without a write");

	AST_STRAP_LOAD: assert property (@(posedge clk) disable iff (!resetn) // R7
		$fell(loading) |-> core_q == $past(core_def) && pll_q == $past(pll_def))
		else $error("strap default not loaded");

	AST_PLL_WR: assert property (@(posedge clk) disable iff (!resetn) // R8
		wr && sel_pll && !loading |=> pll_linear_regulator_level == $past(wdata[2:0]))
		else $error("pll level write lost");

	AST_IRQ: assert property (@(posedge clk) disable iff (!resetn)
		irq == |(ev_q & mask_q))
		else $error("irq disagrees with status");

	AST_PLL_WR_Q: assert property (@(posedge clk) disable iff (!resetn) // R8
		s_pll_wr
		|=> pll_q == $past(wdata[2:0]))
		else $error("pll level field write lost");

	AST_PLL_WR_RD: assert property (@(posedge clk) disable iff (!resetn) // R8 R10
		s_pll_wr_rd
		|=> rdata == {29'h00000000, $past(wdata[2:0], 3)})
		else $error("pll level read back wrong");

	AST_PLL_RD: assert property (@(posedge clk) disable iff (!resetn) // R10
		rd && sel_pll && !loading
		|=> rdata[31:3] == 29'h00000000 && rdata[2:0] == pll_linear_regulator_level)
		else $error("pll level read wrong");

	AST_PLL_HOLD: assert property (@(posedge clk) disable iff (!resetn) // R8
		!loading && !(wr && sel_pll)
		|=> $stable(pll_linear_regulator_level))
		else $error("pll level moved without a write");

	AST_LEVEL_COPY: assert property (@(posedge clk) disable iff (!resetn) // R5 R8
		core_level == core_q && pll_linear_regulator_level == pll_q)
		else $error("level output differs from its field");

	AST_LOAD_OVERRIDE: assert property (@(posedge clk) disable iff (!resetn) // R7
		loading
		|=> core_level == $past(core_def) && pll_linear_regulator_level == $past(pll_def))
		else $error("level not forced to strap default while loading");

	AST_LOAD_STEP: assert property (@(posedge clk) disable iff (!resetn) // R7
		loading && settle_q != 2'h2
		|=> loading && settle_q == $past(settle_q) + 2'h1)
		else $error("strap settle count broken");

	AST_LOAD_EXIT: assert property (@(posedge clk) disable iff (!resetn) // R7
		loading && settle_q == 2'h2
		|=> !loading)
		else $error("strap load did not end");

	AST_RUN_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		!loading
		|=> !loading)
		else $error("strap load restarted without reset");

	AST_STATE_ONEHOT: assert property (@(posedge clk) disable iff (!resetn)
		state_q == SSL_ST_LOAD || state_q == SSL_ST_RUN)
		else $error("load state code illegal");

	AST_SYNC_STEP: assert property (@(posedge clk) disable iff (!resetn)
		1'b1
		|=> sync2_q == $past(sync1_q))
		else $error("synchroniser second stage skipped");

	AST_HEALTH_RSVD: assert property (@(posedge clk) disable iff (!resetn) // R10
		s_health_rd
		|=> rdata[31:25] == 7'h00 && rdata[23:20] == 4'h0 && rdata[18:17] == 2'h0 && rdata[15:10] == 6'h00)
		else $error("health reserved bits not zero");

	AST_UNMAPPED_RD: assert property (@(posedge clk) disable iff (!resetn) // R10
		s_unmapped_rd
		|=> rdata == 32'h00000000)
		else $error("unmapped read not zero");

	AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!resetn)
		!rd
		|=> rdata == 32'h00000000)
		else $error("read data without a read");

	AST_EV_SET: assert property (@(posedge clk) disable iff (!resetn)
		s_flag_rise
		|=> (ev_q & $past(ev_rise)) == $past(ev_rise))
		else $error("rising flag not captured");

	AST_EV_CLR: assert property (@(posedge clk) disable iff (!resetn)
		s_stat_clr
		|=> (ev_q & $past(ev_clr & ~ev_rise)) == 7'h00)
		else $error("status bit not cleared");

	AST_EV_STICKY: assert property (@(posedge clk) disable iff (!resetn)
		!(wr && sel_stat)
		|=> (ev_q & $past(ev_q)) == $past(ev_q))
		else $error("status bit lost without a clear");

	AST_EV_QUIET_LOAD: assert property (@(posedge clk) disable iff (!resetn)
		loading
		|=> (ev_q & ~$past(ev_q)) == 7'h00)
		else $error("status bit set while loading");

	AST_MASK_WR: assert property (@(posedge clk) disable iff (!resetn)
		s_mask_wr
		|=> mask_q == $past(wdata[6:0]))
		else $error("mask write lost");

	AST_MASK_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		!(wr && sel_mask)
		|=> $stable(mask_q))
		else $error("mask moved without a write");

	AST_STAT_RD: assert property (@(posedge clk) disable iff (!resetn)
		rd && sel_stat
		|=> rdata == {25'h0000000, $past(ev_q)})
		else $error("status read wrong");

	AST_MASK_RD: assert property (@(posedge clk) disable iff (!resetn) // R10
		rd && sel_mask
		|=> rdata == {25'h0000000, $past(mask_q)})
		else $error("mask read wrong");

	AST_IRQ_MASKED: assert property (@(posedge clk) disable iff (!resetn)
		mask_q == 7'h00
		|-> !irq)
		else $error("irq raised with all events masked");
endmodule : ssl_regs

// ==== testbench/ssl_regs_bench.sv ====
// Self-checking bench for the supply health and rail level register slice
`include "ssl_defines.svh"
module ssl_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [6:0] st = 7'h00;
	logic [1:0] strap = 2'h0;
	logic [31:0] rdata;
	logic [6:0] core_level;
	logic [2:0] pll_level;
	logic irq;
	logic [31:0] v, r;
	logic [6:0] cur_core = 7'h00;
	logic [2:0] cur_pll = 3'h0;
	int mismatches = 0;
	int total_checks = 0;
	always #5 clk = ~clk;
	ssl_regs u_dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.osc_stable(st[6]), .pll_supply_rail_good(st[5]), .core_supply_rail_good(st[4]),
		.analog_switching_converter_ilim(st[3]), .core_switching_converter_ilim(st[2]),
		.analog_switching_converter_softstart(st[1]), .core_switching_converter_softstart(st[0]),
		.strap_mode(strap), .core_level(core_level), .pll_linear_regulator_level(pll_level), .irq(irq));
	function automatic logic [31:0] health(logic [6:0] s);
		return {7'h00, s[6], 4'h0, s[5], 2'h0, s[4], 6'h00, s[3], s[2], 6'h00, s[1], s[0]};
	endfunction : health
	function automatic logic [6:0] core_def(logic [1:0] s);
		logic [6:0] t[4] = '{`SSL_CORE_DEF_0, `SSL_CORE_DEF_1, `SSL_CORE_DEF_2, `SSL_CORE_DEF_3};
		return t[s];
	endfunction : core_def
	function automatic logic [2:0] pll_def(logic [1:0] s);
		logic [2:0] t[4] = '{`SSL_PLL_DEF_0, `SSL_PLL_DEF_1, `SSL_PLL_DEF_2, `SSL_PLL_DEF_3};
		return t[s];
	endfunction : pll_def
	function automatic logic [6:0] step_core(logic [6:0] c, logic up);
		if (up && c != 7'h7F) return c + 7'h01;
		if (!up && c != 7'h00) return c - 7'h01;
		return c;
	endfunction : step_core
	function automatic logic [2:0] step_pll(logic [2:0] p, logic [2:0] n);
		if (n <= p) return n;
		if (p != 3'h7) return p + 3'h1;
		return p;
	endfunction : step_pll
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wreg(logic [7:0] a, logic [31:0] d);
		@(posedge clk) begin
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
		end
		@(posedge clk) wr <= 1'b0;
	endtask : wreg
	task automatic rreg(logic [7:0] a, output logic [31:0] d);
		@(posedge clk) begin
			addr <= a;
			rd <= 1'b1;
		end
		@(posedge clk) rd <= 1'b0;
		#1 d = rdata;
	endtask : rreg
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic results();
		if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	initial begin
		#200000;
		mismatches++;
		results();
	end
	initial begin
		void'($urandom(32'h93EF));
		for (int s = 0; s < 4; s++) begin
			@(posedge clk) begin
				strap <= s[1:0];
				resetn <= 1'b0;
			end
			cyc(15);
			@(posedge clk) resetn <= 1'b1;
			cyc(4);
			chk("core_level", {25'h0, core_def(strap)}, {25'h0, core_level});
			rreg(`SSL_OFF_CORE, v);
			chk("core reset", {25'h0, core_def(strap)}, v);
			rreg(`SSL_OFF_PLL, v);
			chk("pll reset", {29'h0, pll_def(strap)}, v);
		end
		cur_core = core_def(strap);
		cur_pll = pll_def(strap);
		for (int i = 0; i < 40; i++) begin
			@(posedge clk) st <= (i == 0) ? 7'h7F : 7'($urandom);
			wreg(`SSL_OFF_HEALTH, $urandom);
			cyc(3);
			rreg(`SSL_OFF_HEALTH, v);
			chk("health", health(st), v);
			r = (i == 1) ? 32'hFFFFFFFF : $urandom;
			cur_core = step_core(cur_core, r[31]);
			cur_pll = step_pll(cur_pll, r[30:28]);
			wreg(`SSL_OFF_CORE, {r[31:7], cur_core});
			rreg(`SSL_OFF_CORE, v);
			chk("core", {25'h0, cur_core}, v);
			chk("core_level", {25'h0, cur_core}, {25'h0, core_level});
			wreg(`SSL_OFF_PLL, {~r[31:3], cur_pll});
			rreg(`SSL_OFF_PLL, v);
			chk("pll", {29'h0, cur_pll}, v);
			chk("pll level", {29'h0, cur_pll}, {29'h0, pll_level});
			wreg(8'h44, r);
			rreg(8'h44, v);
			chk("unmapped", 32'h0, v);
			cyc(100);
		end
		for (int k = 0; k < 7; k++) begin
			@(posedge clk) st <= 7'h00;
			cyc(4);
			wreg(`SSL_OFF_IRQ_STAT, 32'h7F);
			wreg(`SSL_OFF_IRQ_MASK, 32'h0);
			@(posedge clk) st <= 7'(1 << k);
			cyc(5);
			chk("irq masked", 32'h0, {31'h0, irq});
			rreg(`SSL_OFF_IRQ_STAT, v);
			chk("irq status", 32'(1 << k), v);
			wreg(`SSL_OFF_IRQ_MASK, 32'hFFFFFFFF);
			cyc(2);
			chk("irq raised", 32'h1, {31'h0, irq});
			rreg(`SSL_OFF_IRQ_MASK, v);
			chk("irq mask", 32'h7F, v);
			wreg(`SSL_OFF_IRQ_STAT, 32'(1 << k));
			cyc(2);
			chk("irq cleared", 32'h0, {31'h0, irq});
			rreg(`SSL_OFF_IRQ_STAT, v);
			chk("irq status clr", 32'h0, v);
		end
		results();
	end
endmodule : ssl_regs_bench
